// [mfd_pkg.sv]
/*
 Constants, field layouts and carrier types for the microword field decoder.
 Assumes one 100 MHz clock and a synchronous active-high reset in every user.

// Overview of operation
// - Take a 56-bit, twelve-field microword every cycle.
// - Variable field: general when 0, floating-point when 1.
// - Sequencer D: general field at 0, branch register at 1.
// - Flag update inhibit 1 keeps the four flags.
// - Bit index: coded bits 12-9, or the n register.
// - Source from low five bits, destination from target field.
// - Destination stays in the source's bank of sixteen.
// - Two-address select 1: same register, target field is misc.
// - Subtract carry flag: 1 no borrow, 0 borrow.
// - Word select: 0 most significant, 1 least significant.
// - Misc 0..3: nop, clear, up, down shared pointer.
// - Misc 4..10: count up A, B, D pointers and combinations.
// - Misc 11..14: shared pointer up or down with counts.
// - Misc 15 is reserved and does nothing.
// - Pass the ALU instruction and one bus pair per cycle.
// - Latch flags at cycle end for next-cycle branching.
// - Four-bit write-only n register replaces bits 12-9.
*/
package mfd_pkg;

  localparam int MW_W       = 56;
  localparam int ALU_W      = 16;
  localparam int PTR_W      = 8;
  localparam int PTR_N      = 4;
  localparam int SRC_W      = 5;
  localparam int NIDX_LSB   = 9;
  localparam int NIDX_W     = 4;
  localparam int BANK_W     = 4;

  localparam int PTR_SMP    = 0;
  localparam int PTR_FPA    = 1;
  localparam int PTR_FPB    = 2;
  localparam int PTR_FPD    = 3;

  localparam logic [PTR_W-1:0]  PTR_RST   = 8'h00;
  localparam logic [NIDX_W-1:0] NREG_RST  = 4'h0;
  localparam logic [ALU_W-1:0]  WORD_RST  = 16'h0000;

  localparam logic [3:0] MISC_NOP       = 4'h0;
  localparam logic [3:0] MISC_SMP_CLR   = 4'h1;
  localparam logic [3:0] MISC_SMP_UP    = 4'h2;
  localparam logic [3:0] MISC_SMP_DN    = 4'h3;
  localparam logic [3:0] MISC_A_UP      = 4'h4;
  localparam logic [3:0] MISC_B_UP      = 4'h5;
  localparam logic [3:0] MISC_D_UP      = 4'h6;
  localparam logic [3:0] MISC_AB_UP     = 4'h7;
  localparam logic [3:0] MISC_AD_UP     = 4'h8;
  localparam logic [3:0] MISC_BD_UP     = 4'h9;
  localparam logic [3:0] MISC_ABD_UP    = 4'ha;
  localparam logic [3:0] MISC_SU_AB     = 4'hb;
  localparam logic [3:0] MISC_SU_D      = 4'hc;
  localparam logic [3:0] MISC_SD_AB     = 4'hd;
  localparam logic [3:0] MISC_SD_D      = 4'he;
  localparam logic [3:0] MISC_RSVD      = 4'hf;

  typedef struct packed {
    logic        fp_type;
    logic        sequencer_input_select;
    logic        flag_update_inhibit;
    logic        bit_index_source;
    logic        twoaddr_select;
    logic        fp_lsw_sel;
    logic [5:0]  viewing_bus_pair;
    logic [3:0]  seq_instr;
    logic [3:0]  branch_cond;
    logic [3:0]  dreg;
    logic [15:0] alu_instr;
    logic [15:0] var_field;
  } mfd_microword_s;

  typedef struct packed {
    logic zero;
    logic negative;
    logic carry;
    logic overflow;
  } mfd_flags_s;

  typedef struct packed {
    logic smp_clr;
    logic smp_up;
    logic smp_dn;
    logic fpa_up;
    logic fpb_up;
    logic fpd_up;
  } mfd_ptr_ops_s;

  localparam mfd_flags_s   FLAGS_RST = '{default: 1'b0};
  localparam mfd_ptr_ops_s OPS_NONE  = '{default: 1'b0};

endpackage : mfd_pkg

// [mfd_ptr_bank.sv]
/*
 Bank of the shared-memory and three floating-point pointer counters.
 Assumes the control strobes are one-cycle levels valid for the whole cycle.
*/
`timescale 1ns/1ns
module mfd_ptr_bank (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic [mfd_pkg::PTR_N-1:0]             clr,
  input  wire logic [mfd_pkg::PTR_N-1:0]             up,
  input  wire logic [mfd_pkg::PTR_N-1:0]             dn,
  input  wire logic [mfd_pkg::PTR_N-1:0]             load,
  input  wire logic [mfd_pkg::PTR_W-1:0]             load_data,
  output logic      [mfd_pkg::PTR_N-1:0][mfd_pkg::PTR_W-1:0] ptr
);

  genvar i;
  generate
    for (i = 0; i < mfd_pkg::PTR_N; i++) begin : g_ptr
      logic [mfd_pkg::PTR_W-1:0] ptr_reg;
      // A bus load wins over any count so software sees the value it wrote.
      always_ff @(posedge clk) begin
        if (rst) begin
          ptr_reg <= mfd_pkg::PTR_RST;
        end else if (load[i]) begin
          ptr_reg <= load_data;
        end else if (clr[i]) begin
          ptr_reg <= mfd_pkg::PTR_RST;
        end else if (up[i]) begin
          ptr_reg <= ptr_reg + 8'h01;
        end else if (dn[i]) begin
          ptr_reg <= ptr_reg - 8'h01;
        end
      end
      assign ptr[i] = ptr_reg;
    end
  endgenerate

endmodule : mfd_ptr_bank

// [mfd_decoder.sv]
/*
 Microword field decoder: splits the microword into ALU, sequencer, bus,
 flag and pointer controls, holds the status flags and the n register.
 Assumes the microword, ALU flags and strobes are synchronous to clk; the
 microword captured at an edge executes during the following cycle.
*/
// The implementer's own choices: the strobed n register write port and pointer load port.
`timescale 1ns/1ns
module mfd_decoder (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire mfd_pkg::mfd_microword_s       microword,
  input  wire logic [14:0]                   branch_addr,
  input  wire logic                          n_wr,
  input  wire logic [mfd_pkg::NIDX_W-1:0]    n_data,
  input  wire mfd_pkg::mfd_flags_s           alu_flags,
  input  wire logic                          alu_sub,
  input  wire logic                          alu_borrow,
  input  wire logic [mfd_pkg::PTR_N-1:0]     ptr_load,
  input  wire logic [mfd_pkg::PTR_W-1:0]     ptr_load_data,
  output logic      [mfd_pkg::ALU_W-1:0]     alu_instr,
  output logic      [mfd_pkg::SRC_W-1:0]     alu_src_reg,
  output logic      [mfd_pkg::SRC_W-1:0]     alu_dst_reg,
  output logic                               alu_dst_en,
  output logic      [3:0]                    seq_instr,
  output logic      [15:0]                   seq_d,
  output logic      [3:0]                    branch_cond,
  output logic      [5:0]                    viewing_bus_pair,
  output logic      [15:0]                   general_field,
  output logic                               general_valid,
  output logic      [15:0]                   fp_op,
  output logic                               fp_op_valid,
  output logic                               fp_lsw_sel,
  output mfd_pkg::mfd_flags_s                status_flags,
  output mfd_pkg::mfd_ptr_ops_s              ptr_ops,
  output logic      [mfd_pkg::PTR_N-1:0][mfd_pkg::PTR_W-1:0] ptr
);

  // Miscellaneous-control decode from the target register field.
  function automatic mfd_pkg::mfd_ptr_ops_s misc_decode(input logic [3:0] code);
    mfd_pkg::mfd_ptr_ops_s o;
    o = mfd_pkg::OPS_NONE;
    case (code)
      mfd_pkg::MISC_NOP:     o = mfd_pkg::OPS_NONE;
      mfd_pkg::MISC_SMP_CLR: o.smp_clr = 1'b1;
      mfd_pkg::MISC_SMP_UP:  o.smp_up = 1'b1;
      mfd_pkg::MISC_SMP_DN:  o.smp_dn = 1'b1;
      mfd_pkg::MISC_A_UP:    o.fpa_up = 1'b1;
      mfd_pkg::MISC_B_UP:    o.fpb_up = 1'b1;
      mfd_pkg::MISC_D_UP:    o.fpd_up = 1'b1;
      mfd_pkg::MISC_AB_UP: begin
        o.fpa_up = 1'b1;
        o.fpb_up = 1'b1;
      end
      mfd_pkg::MISC_AD_UP: begin
        o.fpa_up = 1'b1;
        o.fpd_up = 1'b1;
      end
      mfd_pkg::MISC_BD_UP: begin
        o.fpb_up = 1'b1;
        o.fpd_up = 1'b1;
      end
      mfd_pkg::MISC_ABD_UP: begin
        o.fpa_up = 1'b1;
        o.fpb_up = 1'b1;
        o.fpd_up = 1'b1;
      end
      mfd_pkg::MISC_SU_AB: begin
        o.smp_up = 1'b1;
        o.fpa_up = 1'b1;
        o.fpb_up = 1'b1;
      end
      mfd_pkg::MISC_SU_D: begin
        o.smp_up = 1'b1;
        o.fpd_up = 1'b1;
      end
      mfd_pkg::MISC_SD_AB: begin
        o.smp_dn = 1'b1;
        o.fpa_up = 1'b1;
        o.fpb_up = 1'b1;
      end
      mfd_pkg::MISC_SD_D: begin
        o.smp_dn = 1'b1;
        o.fpd_up = 1'b1;
      end
      mfd_pkg::MISC_RSVD:    o = mfd_pkg::OPS_NONE;
      default:               o = mfd_pkg::OPS_NONE;
    endcase
    return o;
  endfunction : misc_decode

  logic [mfd_pkg::NIDX_W-1:0] n_reg;
  logic                       inhibit_reg;
  logic [mfd_pkg::ALU_W-1:0]  alu_instr_next;
  logic [mfd_pkg::SRC_W-1:0]  dst_next;

  // The n register is write-only; software never reads it back.
  always_ff @(posedge clk) begin
    if (rst) begin
      n_reg <= mfd_pkg::NREG_RST;
    end else if (n_wr) begin
      n_reg <= n_data;
    end
  end

  // The low four bits are never rewritten: the ALU slice receives the
  // destination separately, so an immediate keeps its operand intact.
  always_comb begin
    alu_instr_next = microword.alu_instr;
    if (microword.bit_index_source) begin
      alu_instr_next[mfd_pkg::NIDX_LSB +: mfd_pkg::NIDX_W] = n_reg;
    end
    if (microword.twoaddr_select) begin
      dst_next = microword.alu_instr[mfd_pkg::SRC_W-1:0];
    end else begin
      dst_next = {microword.alu_instr[mfd_pkg::SRC_W-1], microword.dreg};
    end
  end

  // Every field is captured at once so the whole word executes together.
  always_ff @(posedge clk) begin
    if (rst) begin
      alu_instr        <= mfd_pkg::WORD_RST;
      alu_src_reg      <= '0;
      alu_dst_reg      <= '0;
      alu_dst_en       <= 1'b0;
      seq_instr        <= 4'h0;
      branch_cond      <= 4'h0;
      viewing_bus_pair <= 6'h00;
      fp_lsw_sel       <= 1'b0;
      inhibit_reg      <= 1'b1;
    end else begin
      alu_instr        <= alu_instr_next;
      alu_src_reg      <= microword.alu_instr[mfd_pkg::SRC_W-1:0];
      alu_dst_reg      <= dst_next;
      alu_dst_en       <= ~microword.twoaddr_select;
      seq_instr        <= microword.seq_instr;
      branch_cond      <= microword.branch_cond;
      viewing_bus_pair <= microword.viewing_bus_pair;
      fp_lsw_sel       <= microword.fp_lsw_sel;
      inhibit_reg      <= microword.flag_update_inhibit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_d         <= mfd_pkg::WORD_RST;
      general_field <= mfd_pkg::WORD_RST;
      general_valid <= 1'b0;
      fp_op         <= mfd_pkg::WORD_RST;
      fp_op_valid   <= 1'b0;
    end else begin
      seq_d         <= microword.sequencer_input_select ? {1'b0, branch_addr}
                                                        : microword.var_field;
      general_field <= microword.fp_type ? mfd_pkg::WORD_RST : microword.var_field;
      general_valid <= ~microword.fp_type;
      fp_op         <= microword.fp_type ? microword.var_field : mfd_pkg::WORD_RST;
      fp_op_valid   <= microword.fp_type;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_ops <= mfd_pkg::OPS_NONE;
    end else if (microword.twoaddr_select) begin
      ptr_ops <= misc_decode(microword.dreg);
    end else begin
      ptr_ops <= mfd_pkg::OPS_NONE;
    end
  end

  // Flags are sampled at the end of the executing cycle so the very next
  // microword can branch on them.
  always_ff @(posedge clk) begin
    if (rst) begin
      status_flags <= mfd_pkg::FLAGS_RST;
    end else if (!inhibit_reg) begin
      status_flags.zero     <= alu_flags.zero;
      status_flags.negative <= alu_flags.negative;
      status_flags.overflow <= alu_flags.overflow;
      status_flags.carry    <= alu_sub ? ~alu_borrow : alu_flags.carry;
    end
  end

  mfd_ptr_bank u_ptr_bank (
    .clk       (clk),
    .rst       (rst),
    .clr       ({3'b000, ptr_ops.smp_clr}),
    .up        ({ptr_ops.fpd_up, ptr_ops.fpb_up, ptr_ops.fpa_up, ptr_ops.smp_up}),
    .dn        ({3'b000, ptr_ops.smp_dn}),
    .load      (ptr_load),
    .load_data (ptr_load_data),
    .ptr       (ptr)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FLAG_HOLD: assert property (
    inhibit_reg |=> status_flags == $past(status_flags))
    else $error("Flags changed while update was inhibited.");
  AST_FLAG_LOAD: assert property (
    !inhibit_reg |=> status_flags.zero == $past(alu_flags.zero)
                  && status_flags.overflow == $past(alu_flags.overflow))
    else $error("Flags not latched at end of cycle.");
  AST_SUB_CARRY: assert property (
    (!inhibit_reg && alu_sub) |=> status_flags.carry == !$past(alu_borrow))
    else $error("Subtract carry does not show no-borrow.");
  AST_SEQ_D: assert property (
    microword.sequencer_input_select |=> seq_d == {1'b0, $past(branch_addr)})
    else $error("Sequencer D not taken from branch register.");
  AST_VAR_FIELD: assert property (
    microword.fp_type |=> fp_op_valid && !general_valid
                       && fp_op == $past(microword.var_field))
    else $error("Variable field not steered to floating point.");
  AST_SAME_BANK: assert property (
    alu_dst_reg[mfd_pkg::SRC_W-1] == alu_src_reg[mfd_pkg::SRC_W-1])
    else $error("Destination left the source bank.");
  AST_TWOADDR: assert property (
    !microword.twoaddr_select |=> alu_dst_reg[3:0] == $past(microword.dreg) && alu_dst_en)
    else $error("Destination not taken from target field.");
  AST_SAME_REG: assert property (
    microword.twoaddr_select |=> alu_dst_reg == alu_src_reg
                              && alu_instr[3:0] == $past(microword.alu_instr[3:0]))
    else $error("Same-register form altered the instruction.");
  AST_NSUB: assert property (
    microword.bit_index_source |=> alu_instr[12:9] == $past(n_reg))
    else $error("Bit index not replaced by n register.");
  AST_SMP_CLR: assert property (
    (ptr_ops.smp_clr && !ptr_load[mfd_pkg::PTR_SMP]) |=> ptr[mfd_pkg::PTR_SMP] == 8'h00)
    else $error("Shared pointer not cleared at end of cycle.");
  AST_RSVD: assert property (
    (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_RSVD)
      |=> ptr_ops == mfd_pkg::OPS_NONE)
    else $error("Reserved code produced a pointer action.");
  AST_ABD: assert property (
    (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_ABD_UP) ##1 (ptr_load == 4'h0)
      |=> ptr[mfd_pkg::PTR_FPD] == $past(ptr[mfd_pkg::PTR_FPD]) + 8'h01)
    else $error("Destination pointer not counted for code 1010.");

  // Field-by-field checks, so that one miswired bit shows in the cycle it acts.
  AST_GEN_FIELD: assert property (
    !microword.fp_type |=> general_valid && !fp_op_valid
                        && general_field == $past(microword.var_field))
    else $error("Variable field not steered to general field.");
  AST_SEQ_GEN: assert property (
    !microword.sequencer_input_select |=> seq_d == $past(microword.var_field))
    else $error("Sequencer D not taken from general field.");
  AST_NIDX_CODED: assert property (
    !microword.bit_index_source |=> alu_instr[12:9] == $past(microword.alu_instr[12:9]))
    else $error("Coded bit index was altered.");
  AST_PASS: assert property (
    1'b1 |=> viewing_bus_pair == $past(microword.viewing_bus_pair)
          && alu_instr[15:13] == $past(microword.alu_instr[15:13])
          && alu_instr[8:0] == $past(microword.alu_instr[8:0]))
    else $error("ALU instruction or bus pair not passed through.");
  AST_WORD_SEL: assert property (
    1'b1 |=> fp_lsw_sel == $past(microword.fp_lsw_sel))
    else $error("Word select not passed through.");
  AST_SRC_REG: assert property (
    1'b1 |=> alu_src_reg == $past(microword.alu_instr[mfd_pkg::SRC_W-1:0]))
    else $error("Source register not taken from low five bits.");
  AST_NO_MISC: assert property (
    !microword.twoaddr_select |=> ptr_ops == mfd_pkg::OPS_NONE)
    else $error("Pointer action decoded from a destination field.");
  AST_NOP: assert property (
    (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_NOP)
      |=> ptr_ops == mfd_pkg::OPS_NONE)
    else $error("No-operation code produced a pointer action.");
  AST_CLR_DEC: assert property (
    (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_SMP_CLR)
      |=> ptr_ops.smp_clr && !ptr_ops.smp_up && !ptr_ops.smp_dn)
    else $error("Clear code not decoded alone.");
  AST_SD_AB: assert property (
    (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_SD_AB)
      |=> ptr_ops.smp_dn && ptr_ops.fpa_up && ptr_ops.fpb_up
          && !ptr_ops.smp_up && !ptr_ops.fpd_up)
    else $error("Code 1101 not decoded as down with A and B up.");
  AST_SMP_UP: assert property (
    (ptr_ops.smp_up && !ptr_load[mfd_pkg::PTR_SMP])
      |=> ptr[mfd_pkg::PTR_SMP] == $past(ptr[mfd_pkg::PTR_SMP]) + 8'h01)
    else $error("Shared pointer did not count up.");
  AST_SMP_DN: assert property (
    (ptr_ops.smp_dn && !ptr_load[mfd_pkg::PTR_SMP])
      |=> ptr[mfd_pkg::PTR_SMP] == $past(ptr[mfd_pkg::PTR_SMP]) - 8'h01)
    else $error("Shared pointer did not count down.");
  AST_FPA_UP: assert property (
    (ptr_ops.fpa_up && !ptr_load[mfd_pkg::PTR_FPA])
      |=> ptr[mfd_pkg::PTR_FPA] == $past(ptr[mfd_pkg::PTR_FPA]) + 8'h01)
    else $error("Source A pointer did not count up.");
  AST_FPB_UP: assert property (
    (ptr_ops.fpb_up && !ptr_load[mfd_pkg::PTR_FPB])
      |=> ptr[mfd_pkg::PTR_FPB] == $past(ptr[mfd_pkg::PTR_FPB]) + 8'h01)
    else $error("Source B pointer did not count up.");
  AST_FPD_UP: assert property (
    (ptr_ops.fpd_up && !ptr_load[mfd_pkg::PTR_FPD])
      |=> ptr[mfd_pkg::PTR_FPD] == $past(ptr[mfd_pkg::PTR_FPD]) + 8'h01)
    else $error("Destination pointer did not count up.");
  AST_FLAG_NEG: assert property (
    !inhibit_reg |=> status_flags.negative == $past(alu_flags.negative))
    else $error("Negative flag not updated.");
  AST_ADD_CARRY: assert property (
    (!inhibit_reg && !alu_sub) |=> status_flags.carry == $past(alu_flags.carry))
    else $error("Carry flag not latched from the ALU.");

  COV_INHIBIT: cover property (inhibit_reg ##1 !inhibit_reg);
  COV_NSUB:    cover property (microword.bit_index_source && !microword.twoaddr_select);
  COV_SD_D:    cover property (microword.twoaddr_select && microword.dreg == mfd_pkg::MISC_SD_D);
  COV_FP:      cover property (microword.fp_type ##1 !microword.fp_type);

endmodule : mfd_decoder

// [mfd_alu_model.sv]
/*
 Behavioural model of the ALU slice that sits beyond the decoder.
 Assumes the bench asks for a flag set together with the word that makes it.
*/
`timescale 1ns/1ns
module mfd_alu_model (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [5:0]     alu_req,
  output mfd_pkg::mfd_flags_s alu_flags,
  output logic                alu_sub,
  output logic                alu_borrow
);
  // Results appear in the execution cycle, one edge after the word is issued.
  always_ff @(posedge clk) begin
    if (rst) begin
      alu_flags  <= mfd_pkg::FLAGS_RST;
      alu_sub    <= 1'b0;
      alu_borrow <= 1'b0;
    end else begin
      alu_flags  <= alu_req[5:2];
      alu_sub    <= alu_req[1];
      alu_borrow <= alu_req[0];
    end
  end
endmodule : mfd_alu_model

// [microword_field_decoder_tb.sv]
/*
 Self-checking bench for the microword field decoder with an ALU slice model.
 Assumes decoded fields stand one edge after the word is taken.
*/
`timescale 1ns/1ns
module microword_field_decoder_tb;
  localparam logic [15:0] AU = 16'h2d90;
  localparam logic [15:0] BU = 16'h2ea0;
  localparam logic [15:0] DU = 16'h5740;
  localparam logic [15:0] SU = 16'h1804;
  localparam logic [15:0] SD = 16'h6008;
  logic                    clk, rst, n_wr, alu_sub, alu_borrow, alu_dst_en;
  logic                    general_valid, fp_op_valid, fp_lsw_sel;
  mfd_pkg::mfd_microword_s microword, idle_w, w;
  mfd_pkg::mfd_flags_s     alu_flags, status_flags;
  mfd_pkg::mfd_ptr_ops_s   ptr_ops;
  logic [14:0]             branch_addr;
  logic [3:0]              n_data, ptr_load, seq_instr, branch_cond;
  logic [7:0]              ptr_load_data;
  logic [5:0]              alu_req, viewing_bus_pair;
  logic [15:0]             alu_instr, seq_d, general_field, fp_op;
  logic [4:0]              alu_src_reg, alu_dst_reg;
  logic [3:0][7:0]         ptr;
  logic [7:0]              e [4];
  int                      miscompares, total_checks;

  mfd_decoder u_mfd_decoder (.clk, .rst, .microword, .branch_addr, .n_wr, .n_data,
    .alu_flags, .alu_sub, .alu_borrow, .ptr_load, .ptr_load_data, .alu_instr, .alu_src_reg,
    .alu_dst_reg, .alu_dst_en, .seq_instr, .seq_d, .branch_cond, .viewing_bus_pair,
    .general_field, .general_valid, .fp_op, .fp_op_valid, .fp_lsw_sel, .status_flags,
    .ptr_ops, .ptr);
  mfd_alu_model u_mfd_alu_model (.clk, .rst, .alu_req, .alu_flags, .alu_sub, .alu_borrow);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Returning on the word's idle follower keeps pointer actions to a single cycle.
  task automatic issue(input mfd_pkg::mfd_microword_s wd, input logic [5:0] req);
    @(posedge clk);
    microword <= wd;
    alu_req   <= req;
    @(posedge clk);
    microword <= idle_w;
    #1;
  endtask : issue

  task automatic t_flags;
    w = idle_w;
    w.flag_update_inhibit = 1'b0;
    issue(w, 6'b1010_00);
    chk(status_flags, 4'h0, "flags early");
    tick;
    chk(status_flags, 4'ha, "flags load");
    issue(idle_w, 6'b0101_00);
    tick;
    chk(status_flags, 4'ha, "flags hold");
    issue(w, 6'b0000_10);
    tick;
    chk(status_flags, 4'h2, "no borrow");
    issue(w, 6'b0010_11);
    tick;
    chk(status_flags, 4'h0, "borrow");
    issue(w, 6'b0101_00);
    tick;
    chk(status_flags, 4'h5, "flags neg ovf");
    $display("t_flags done");
  endtask : t_flags

  task automatic t_fields;
    for (int i = 0; i < 2; i++) begin
      w = idle_w;
      w.fp_type = i[0];
      w.sequencer_input_select = i[0];
      w.fp_lsw_sel = i[0];
      w.viewing_bus_pair = 6'h2b;
      w.seq_instr = 4'h9;
      w.branch_cond = 4'h6;
      w.alu_instr = 16'h1234;
      w.var_field = 16'h5a3c;
      issue(w, 6'h00);
      chk({general_valid, fp_op_valid}, i ? 2'b01 : 2'b10, "kind");
      chk(i ? fp_op : general_field, 16'h5a3c, "variable");
      chk(i ? general_field : fp_op, 16'h0000, "other");
      chk(seq_d, i ? 16'h7abc : 16'h5a3c, "seq d");
      chk(fp_lsw_sel, i[0], "word sel");
      chk({viewing_bus_pair, seq_instr, branch_cond, alu_instr}, 30'h2b961234, "pass");
    end
    $display("t_fields done");
  endtask : t_fields

  task automatic t_dst;
    w = idle_w;
    w.twoaddr_select = 1'b0;
    w.dreg = 4'h3;
    w.alu_instr = 16'h0015;
    issue(w, 6'h00);
    chk({alu_dst_en, alu_src_reg, alu_dst_reg}, {1'b1, 5'h15, 5'h13}, "two addr");
    chk(ptr_ops, 6'h00, "no misc");
    w.twoaddr_select = 1'b1;
    w.alu_instr = 16'h000b;
    issue(w, 6'h00);
    chk({alu_dst_en, alu_src_reg, alu_dst_reg, alu_instr}, 27'h16b000b, "one addr");
    $display("t_dst done");
  endtask : t_dst

  task automatic t_nreg;
    @(posedge clk);
    n_wr   <= 1'b1;
    n_data <= 4'hb;
    @(posedge clk);
    n_wr   <= 1'b0;
    w = idle_w;
    w.alu_instr = 16'hf1ff;
    issue(w, 6'h00);
    chk(alu_instr, 16'hf1ff, "coded index");
    w.bit_index_source = 1'b1;
    issue(w, 6'h00);
    chk(alu_instr, 16'hf7ff, "n index");
    $display("t_nreg done");
  endtask : t_nreg

  task automatic t_misc;
    @(posedge clk);
    ptr_load      <= 4'hf;
    ptr_load_data <= 8'h10;
    @(posedge clk);
    ptr_load      <= 4'h0;
    for (int k = 0; k < 4; k++) e[k] = 8'h10;
    for (int c = 0; c < 16; c++) begin
      w = idle_w;
      w.dreg = c[3:0];
      issue(w, 6'h00);
      chk(ptr_ops, {c == 1, SU[c], SD[c], AU[c], BU[c], DU[c]}, "ops");
      e[0] = (c == 1) ? 8'h00 : e[0] + SU[c] - SD[c];
      e[1] = e[1] + AU[c];
      e[2] = e[2] + BU[c];
      e[3] = e[3] + DU[c];
      tick;
      for (int k = 0; k < 4; k++) chk(ptr[k], e[k], "pointer");
    end
    $display("t_misc done");
  endtask : t_misc

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    idle_w = '0;
    idle_w.twoaddr_select = 1'b1;
    idle_w.flag_update_inhibit = 1'b1;
    microword = idle_w;
    rst = 1'b1;
    n_wr = 1'b0;
    n_data = 4'h0;
    ptr_load = 4'h0;
    ptr_load_data = 8'h00;
    alu_req = 6'h00;
    branch_addr = 15'h7abc;
    miscompares = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_flags;
    t_fields;
    t_dst;
    t_nreg;
    t_misc;
    print_verdict;
  end

  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule : microword_field_decoder_tb
